// [hw/motor_feedback_param_regs.sv]
// Feedback and motor parameter registers behind a two-wire slave port.
// Assumes scl_in and sda_in are already synchronous to clock, and that the
// board resolves the open-drain data line from sda_oe.
// Notes on behaviour
// - Speed is sixteen bits, high at 0x11, low at 0x12; read high first.
// - Speed count is one tenth of a hertz.
// - Period is sixteen bits, high at 0x13, low at 0x14; high first.
// - Period count is ten microseconds.
// - Velocity constant at 0x15/0x16, twice digital constant; high first.
// - Address 0x19 gives estimated rotor position plus advance angle.
// - Supply code at 0x1A; code times 30 V over 256.
// - Address 0x1B gives the raw speed request, FF is full scale.
// - Address 0x1C gives bits 8 to 1 of the buffered request.
// - Fault byte at 0x1E, bits 7:6 zero, six fault flags below.
// - Bit 7 of 0x20 picks a 25 kHz or 50 kHz carrier.
// - Resistance code decodes as significand shifted left by shift field.
// - Bit 7 of 0x21 picks full or half cycle adjustment.
// - Velocity constant code decodes as significand shifted by shift field.
// - Bit 7 of 0x22 picks fixed or speed and supply dependent advance.
// - Advance delay is 2.5 us times shifted significand.
// - Parameters come from a store holding 0x4A, 0x4E and 0x2A.
// - A reload request copies the store into the parameter registers.
`timescale 1ns/1ps
`default_nettype none
`include "motor_fb_defines.svh"
module motor_feedback_param_regs #(
   parameter int PWM_LOW_CYCLES = `CLOCK_HZ / `PWM_LOW_HZ,
   parameter int PWM_HIGH_CYCLES = `CLOCK_HZ / `PWM_HIGH_HZ,
   parameter logic [6:0] BUS_ADDRESS = `DEVICE_ADDRESS
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Two-wire bus pins.
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Feedback from the motor engines.
   input wire logic [15:0] rotor_velocity_value,
   input wire logic [15:0] electrical_period_value,
   input wire logic [15:0] measured_velocity_constant,
   input wire logic [7:0] rotor_position_estimate,
   input wire logic [7:0] supply_level,
   input wire logic [7:0] raw_speed_request,
   input wire logic [8:0] buffered_speed_request,
   input wire logic [5:0] fault_flags,
   // Reload request from the control register.
   input wire logic nonvolatile_reload,
   // Decoded motor parameters.
   output logic params_loading,
   output logic pwm_rate_select,
   output logic pwm_carrier_tick,
   output logic [10:0] phase_resistance_code,
   output logic closed_loop_adjust_span,
   output logic [10:0] velocity_constant_code,
   output logic advance_method_select,
   output logic [10:0] advance_time_setting,
   output logic [19:0] advance_delay_cycles
);

   // Refuse carrier counts the counter cannot serve.
   if (PWM_HIGH_CYCLES < 2 || PWM_LOW_CYCLES < PWM_HIGH_CYCLES ||
       PWM_LOW_CYCLES > 65536) begin : g_pwm_check
      $error("carrier cycle counts out of range");
   end

   localparam logic [15:0] LOW_M1 = 16'(PWM_LOW_CYCLES - 1);
   localparam logic [15:0] HIGH_M1 = 16'(PWM_HIGH_CYCLES - 1);

   // Significand shifted left by the shift count of a parameter code.
   function automatic logic [10:0] shift_decode(input logic [6:0] code);
      shift_decode = {7'h00, code[`CODE_SIG_MSB:0]} <<
                     code[`CODE_SHIFT_MSB:`CODE_SHIFT_LSB];
   endfunction : shift_decode

   // Advance units of 2.5 us turned into clock cycles, rounded up.
   function automatic logic [19:0] advance_cycles(input logic [10:0] u);
      int unsigned ns;
      ns = 32'(u) * `ADVANCE_STEP_NS;
      advance_cycles = 20'((ns + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS);
   endfunction : advance_cycles

   motor_fb_pkg::link_state_t state;
   motor_fb_pkg::byte_t shift_reg;
   motor_fb_pkg::byte_t tx_byte;
   motor_fb_pkg::byte_t tx_next;
   motor_fb_pkg::byte_t pointer;
   motor_fb_pkg::byte_t speed_low_snap;
   motor_fb_pkg::byte_t period_low_snap;
   motor_fb_pkg::byte_t vconst_low_snap;
   motor_fb_pkg::byte_t param [3];
   logic [2:0] bit_cnt;
   logic read_mode;
   logic pointer_phase;
   logic scl_q;
   logic sda_q;
   logic fetch;
   logic host_write;
   motor_fb_pkg::byte_t write_data;
   logic [1:0] load_idx;
   logic load_issue;
   logic store_valid;
   motor_fb_pkg::byte_t store_data;
   logic [1:0] store_idx;
   logic [15:0] pwm_cnt;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   // Bus line edges and frame conditions.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end
   assign scl_rise = scl_in && !scl_q;
   assign scl_fall = !scl_in && scl_q;
   assign start_seen = scl_in && scl_q && sda_q && !sda_in;
   assign stop_seen = scl_in && scl_q && !sda_q && sda_in;

   // Byte read back for the register at the pointer.
   function automatic motor_fb_pkg::byte_t read_value(
      input motor_fb_pkg::byte_t a);
      case (a)
         `REG_SPEED_HIGH: read_value = rotor_velocity_value[15:8];
         `REG_SPEED_LOW: read_value = speed_low_snap;
         `REG_PERIOD_HIGH: read_value = electrical_period_value[15:8];
         `REG_PERIOD_LOW: read_value = period_low_snap;
         `REG_VCONST_HIGH: read_value = measured_velocity_constant[15:8];
         `REG_VCONST_LOW: read_value = vconst_low_snap;
         `REG_POSITION: read_value = rotor_position_estimate;
         `REG_SUPPLY: read_value = supply_level;
         `REG_RAW_SPEED: read_value = raw_speed_request;
         `REG_BUF_SPEED: read_value = buffered_speed_request[8:1];
         `REG_FAULTS: read_value = {2'b00, fault_flags};
         `REG_PARAM1: read_value = param[0];
         `REG_PARAM2: read_value = param[1];
         `REG_PARAM3: read_value = param[2];
         default: read_value = 8'h00;
      endcase
   endfunction : read_value

   // Byte that a fetch would load now; a process, so feedback edits count.
   always_comb begin
      tx_next = read_value(pointer);
   end

   // Fetch a byte to send: after the address ack or after a host ack.
   assign fetch = scl_fall && !stop_seen &&
                  ((state == motor_fb_pkg::st_ack_addr && sda_oe &&
                    read_mode) || state == motor_fb_pkg::st_rd_next);
   // A data byte written after the pointer byte.
   assign host_write = scl_rise && state == motor_fb_pkg::st_wr_byte &&
                       bit_cnt == 3'h7 && !pointer_phase;
   assign write_data = {shift_reg[6:0], sda_in};

   // Two-wire slave: addressing, pointer, writes and reads.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= motor_fb_pkg::st_idle;
         shift_reg <= 8'h00;
         tx_byte <= 8'h00;
         bit_cnt <= 3'h0;
         read_mode <= 1'b0;
         pointer_phase <= 1'b0;
         pointer <= 8'h00;
         sda_oe <= 1'b0;
      end else if (start_seen) begin
         state <= motor_fb_pkg::st_addr;
         bit_cnt <= 3'h0;
         sda_oe <= 1'b0;
      end else if (stop_seen) begin
         state <= motor_fb_pkg::st_idle;
         sda_oe <= 1'b0;
      end else if (fetch) begin
         tx_byte <= tx_next;
         sda_oe <= !tx_next[7];
         pointer <= pointer + 8'h01;
         bit_cnt <= 3'h0;
         state <= motor_fb_pkg::st_rd_byte;
      end else begin
         case (state)
            motor_fb_pkg::st_addr: begin
               if (scl_rise) begin
                  shift_reg <= write_data;
                  bit_cnt <= bit_cnt + 3'h1;
                  if (bit_cnt == 3'h7) begin
                     read_mode <= sda_in;
                     pointer_phase <= 1'b1;
                     if (shift_reg[6:0] == BUS_ADDRESS) begin
                        state <= motor_fb_pkg::st_ack_addr;
                     end else begin
                        state <= motor_fb_pkg::st_idle;
                     end
                  end
               end
            end
            motor_fb_pkg::st_ack_addr, motor_fb_pkg::st_ack_wr: begin
               if (scl_fall) begin
                  sda_oe <= !sda_oe;
                  if (sda_oe) begin
                     state <= motor_fb_pkg::st_wr_byte;
                  end
               end
            end
            motor_fb_pkg::st_wr_byte: begin
               if (scl_rise) begin
                  shift_reg <= write_data;
                  bit_cnt <= bit_cnt + 3'h1;
                  if (bit_cnt == 3'h7) begin
                     pointer_phase <= 1'b0;
                     if (pointer_phase) begin
                        pointer <= write_data;
                     end else begin
                        pointer <= pointer + 8'h01;
                     end
                     state <= motor_fb_pkg::st_ack_wr;
                  end
               end
            end
            motor_fb_pkg::st_rd_byte: begin
               if (scl_fall) begin
                  sda_oe <= !tx_byte[6];
                  tx_byte <= {tx_byte[6:0], 1'b0};
               end
               if (scl_rise) begin
                  bit_cnt <= bit_cnt + 3'h1;
                  if (bit_cnt == 3'h7) begin
                     state <= motor_fb_pkg::st_rd_ack;
                  end
               end
            end
            motor_fb_pkg::st_rd_ack: begin
               if (scl_fall) begin
                  sda_oe <= 1'b0;
               end
               if (scl_rise) begin
                  if (sda_in) begin
                     state <= motor_fb_pkg::st_idle;
                  end else begin
                     state <= motor_fb_pkg::st_rd_next;
                  end
               end
            end
            default: begin
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

   // Open-drain line: only ever pulled low.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   // Low bytes frozen when their high byte is fetched.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         speed_low_snap <= 8'h00;
         period_low_snap <= 8'h00;
         vconst_low_snap <= 8'h00;
      end else if (fetch) begin
         if (pointer == `REG_SPEED_HIGH) begin
            speed_low_snap <= rotor_velocity_value[7:0];
         end
         if (pointer == `REG_PERIOD_HIGH) begin
            period_low_snap <= electrical_period_value[7:0];
         end
         if (pointer == `REG_VCONST_HIGH) begin
            vconst_low_snap <= measured_velocity_constant[7:0];
         end
      end
   end

   // Reload sequencer: starts at reset release and on each request made while not loading.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         params_loading <= 1'b1;
         load_issue <= 1'b1;
         load_idx <= 2'h0;
      end else if (!params_loading && nonvolatile_reload) begin
         params_loading <= 1'b1;
         load_issue <= 1'b1;
         load_idx <= 2'h0;
      end else if (params_loading) begin
         if (load_idx == 2'h2) begin
            load_issue <= 1'b0;
         end
         if (load_issue) begin
            load_idx <= load_idx + 2'h1;
         end
         if (store_valid && store_idx == 2'h2) begin
            params_loading <= 1'b0;
         end
      end
   end

   // Index of the byte now returning from the store.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         store_idx <= 2'h0;
      end else begin
         store_idx <= load_idx;
      end
   end

   param_store #(
      .DEPTH(3),
      .WIDTH(8)
   ) u_store (
      .clock(clock),
      .rst(rst),
      .rd_en(load_issue),
      .rd_addr(load_idx),
      .rd_data(store_data),
      .rd_valid(store_valid)
   );

   // Parameter registers: store data wins, host writes are dropped while loading.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         param[0] <= 8'h00;
         param[1] <= 8'h00;
         param[2] <= 8'h00;
      end else if (store_valid) begin
         param[store_idx] <= store_data;
      end else if (host_write && !params_loading &&
                   pointer >= `REG_PARAM1 && pointer <= `REG_PARAM3) begin
         param[2'(pointer - `REG_PARAM1)] <= write_data;
      end
   end

   // Decoded parameters for the motor engines.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pwm_rate_select <= 1'b0;
         phase_resistance_code <= 11'h000;
         closed_loop_adjust_span <= 1'b0;
         velocity_constant_code <= 11'h000;
         advance_method_select <= 1'b0;
         advance_time_setting <= 11'h000;
         advance_delay_cycles <= 20'h00000;
      end else begin
         pwm_rate_select <= param[0][`PARAM_MODE_BIT];
         phase_resistance_code <= shift_decode(param[0][6:0]);
         closed_loop_adjust_span <= param[1][`PARAM_MODE_BIT];
         velocity_constant_code <= shift_decode(param[1][6:0]);
         advance_method_select <= param[2][`PARAM_MODE_BIT];
         advance_time_setting <= shift_decode(param[2][6:0]);
         advance_delay_cycles <=
            advance_cycles(shift_decode(param[2][6:0]));
      end
   end

   // Carrier tick: one pulse per carrier period at the selected rate.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pwm_cnt <= 16'h0000;
         pwm_carrier_tick <= 1'b0;
      end else if (pwm_cnt >= (pwm_rate_select ? HIGH_M1 : LOW_M1)) begin
         pwm_cnt <= 16'h0000;
         pwm_carrier_tick <= 1'b1;
      end else begin
         pwm_cnt <= pwm_cnt + 16'h0001;
         pwm_carrier_tick <= 1'b0;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence reload_busy_s;
      params_loading [*4];
   endsequence
   sequence reload_done_s;
      !params_loading && param[0] == `PARAM1_DEFAULT &&
      param[1] == `PARAM2_DEFAULT && param[2] == `PARAM3_DEFAULT;
   endsequence

   reload_sequence_a: assert property (nonvolatile_reload && !params_loading |=> reload_busy_s ##1 reload_done_s) else $error("reload did not restore store");
   carrier_low_a: assert property (!pwm_rate_select && pwm_cnt == LOW_M1 |=> pwm_carrier_tick) else $error("slow carrier tick late");
   carrier_high_a: assert property (pwm_carrier_tick |-> $past(pwm_cnt) >= HIGH_M1) else $error("carrier tick early");
   resistance_decode_a: assert property (##1 phase_resistance_code == ($past(11'(param[0][3:0])) << $past(param[0][6:4]))) else $error("resistance decode wrong");
   vconst_decode_a: assert property (##1 velocity_constant_code == ($past(11'(param[1][3:0])) << $past(param[1][6:4]))) else $error("constant decode wrong");
   adjust_span_a: assert property (##1 closed_loop_adjust_span == $past(param[1][7])) else $error("adjust span wrong");
   advance_mode_a: assert property (##1 advance_method_select == $past(param[2][7])) else $error("advance mode wrong");
   advance_delay_a: assert property (##2 advance_delay_cycles == 20'((32'(advance_time_setting) * 2500 + 7) / 8)) else $error("advance delay wrong");
   speed_snapshot_a: assert property (fetch && pointer == `REG_SPEED_HIGH |=> speed_low_snap == $past(rotor_velocity_value[7:0]) && tx_byte == $past(rotor_velocity_value[15:8])) else $error("speed pair not coherent");
   fault_byte_a: assert property (fetch && pointer == `REG_FAULTS |=> tx_byte == {2'b00, $past(fault_flags)}) else $error("fault byte wrong");
   buffered_speed_a: assert property (fetch && pointer == `REG_BUF_SPEED |=> tx_byte == $past(buffered_speed_request[8:1])) else $error("buffered request wrong");

endmodule : motor_feedback_param_regs
`default_nettype wire

// [common/motor_fb_defines.svh]
// Constants of the motor feedback and parameter register bank.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef MOTOR_FB_DEFINES_SVH
`define MOTOR_FB_DEFINES_SVH

// Register offsets on the two-wire bus.
`define REG_SPEED_HIGH 8'h11
`define REG_SPEED_LOW 8'h12
`define REG_PERIOD_HIGH 8'h13
`define REG_PERIOD_LOW 8'h14
`define REG_VCONST_HIGH 8'h15
`define REG_VCONST_LOW 8'h16
`define REG_POSITION 8'h19
`define REG_SUPPLY 8'h1A
`define REG_RAW_SPEED 8'h1B
`define REG_BUF_SPEED 8'h1C
`define REG_FAULTS 8'h1E
`define REG_PARAM1 8'h20
`define REG_PARAM2 8'h21
`define REG_PARAM3 8'h22

// Field positions inside the parameter registers and the fault byte.
`define PARAM_MODE_BIT 7
`define CODE_SHIFT_MSB 6
`define CODE_SHIFT_LSB 4
`define CODE_SIG_MSB 3
`define FAULT_USED_MSB 5

// Factory contents of the nonvolatile parameter store.
`define PARAM1_DEFAULT 8'h4A
`define PARAM2_DEFAULT 8'h4E
`define PARAM3_DEFAULT 8'h2A

// Timing: clock rate, carrier rates and the advance step.
`define CLOCK_HZ 125000000
`define CLOCK_PERIOD_NS 8
`define PWM_LOW_HZ 25000
`define PWM_HIGH_HZ 50000
`define ADVANCE_STEP_NS 2500

// Bus address of the device on the two-wire bus.
`define DEVICE_ADDRESS 7'h52

`endif

// [common/motor_fb_pkg.sv]
// Types shared by the motor feedback register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package motor_fb_pkg;

   typedef logic [7:0] byte_t;

   // Two-wire slave states.
   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_addr = 3'b001,
      st_ack_addr = 3'b010,
      st_wr_byte = 3'b011,
      st_ack_wr = 3'b100,
      st_rd_byte = 3'b101,
      st_rd_ack = 3'b110,
      st_rd_next = 3'b111
   } link_state_t;

endpackage : motor_fb_pkg

// [hw/param_store.sv]
// Nonvolatile parameter store holding the factory motor parameters.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "motor_fb_defines.svh"
module param_store #(
   parameter int DEPTH = 3,
   parameter int WIDTH = 8
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Read port.
   input wire logic rd_en,
   input wire logic [1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data,
   output logic rd_valid
);

   // Refuse a shape that the stored image cannot fill.
   if (DEPTH != 3 || WIDTH != 8) begin : g_shape_check
      $error("param_store supports only three bytes of eight bits");
   end

   // Stored image; the contents are fixed at manufacture.
   function automatic logic [WIDTH-1:0] image(input logic [1:0] a);
      case (a)
         2'h0: image = `PARAM1_DEFAULT;
         2'h1: image = `PARAM2_DEFAULT;
         2'h2: image = `PARAM3_DEFAULT;
         default: image = 8'h00;
      endcase
   endfunction : image

   // Read data leaves from a register one cycle after the request.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_en;
         if (rd_en) begin
            rd_data <= image(rd_addr);
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   store_read_a: assert property (rd_en |=> rd_valid && rd_data == image($past(rd_addr))) else $error("store read wrong");

endmodule : param_store
`default_nettype wire

// [testbench/bus_host_model.sv]
// Host model that masters the two-wire bus of the register bank.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module bus_host_model (
   // Clock.
   input wire logic clock,
   // Bus lines.
   output logic scl,
   output logic sda_drive,
   input wire logic sda_line
);
   // Both lines idle high until a transfer begins.
   initial begin
      scl = 1'b1;
      sda_drive = 1'b1;
   end

   // Waits one third of a bus bit.
   task automatic half();
      repeat (8) @(posedge clock);
   endtask : half

   // Issues a start, or a repeated start while the clock is low.
   task automatic start();
      sda_drive <= 1'b1;
      half();
      scl <= 1'b1;
      half();
      sda_drive <= 1'b0;
      half();
      scl <= 1'b0;
      half();
   endtask : start

   // Issues a stop condition and leaves the bus idle.
   task automatic stop();
      sda_drive <= 1'b0;
      half();
      scl <= 1'b1;
      half();
      sda_drive <= 1'b1;
      half();
   endtask : stop

   // Clocks one bit out and returns the level seen while clock is high.
   task automatic bit_cycle(input logic b, output logic seen);
      sda_drive <= b;
      half();
      scl <= 1'b1;
      half();
      seen = sda_line;
      scl <= 1'b0;
      half();
   endtask : bit_cycle

   // Sends a byte msb first, then releases the line for the acknowledge.
   task automatic send(input motor_fb_pkg::byte_t b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(b[i], s);
      end
      bit_cycle(1'b1, s);
      ack = ~s;
   endtask : send

   // Receives a byte; a released line reads high through the pull-up.
   task automatic recv(input logic last, output motor_fb_pkg::byte_t b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b1, s);
         b[i] = s;
      end
      bit_cycle(last, s);
   endtask : recv
endmodule : bus_host_model
`default_nettype wire

// [testbench/motor_feedback_param_regs_test.sv]
// Self-checking bench for the motor feedback and parameter registers.
// Assumes the design files, the defines header and the bus host model.
`timescale 1ns/1ps
`default_nettype none
`include "motor_fb_defines.svh"
module motor_feedback_param_regs_test;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic reload = 1'b0;
   logic [15:0] speed = 16'h01FF;
   logic [15:0] period = 16'h1234;
   logic [15:0] vconst = 16'hABCD;
   logic [8:0] buf_speed = 9'h155;
   logic [7:0] supply = 8'h67;
   logic [5:0] faults = 6'h2D;
   logic stray_ack;
   logic scl, sda_drive, sda_line, sda_out, sda_oe;
   logic loading, rate, tick, span, method;
   logic [10:0] resist, kconst, adv;
   logic [19:0] delay;
   motor_fb_pkg::byte_t rd [6];
   int n_errors = 0;
   int comparisons = 0;

   // Clock of 8 ns; the data wire is pulled up and pulled low by either end.
   always #4 clock = ~clock;
   assign sda_line = sda_drive & ~sda_oe;

   bus_host_model bus_host_model_i (.clock(clock), .scl(scl),
      .sda_drive(sda_drive), .sda_line(sda_line));

   motor_feedback_param_regs #(.PWM_LOW_CYCLES(20), .PWM_HIGH_CYCLES(10))
   motor_feedback_param_regs_i (.clock(clock), .rst(rst), .scl_in(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .rotor_velocity_value(speed), .electrical_period_value(period),
      .measured_velocity_constant(vconst), .rotor_position_estimate(8'h5A),
      .supply_level(supply), .raw_speed_request(8'hFF),
      .buffered_speed_request(buf_speed), .fault_flags(faults),
      .nonvolatile_reload(reload), .params_loading(loading),
      .pwm_rate_select(rate), .pwm_carrier_tick(tick),
      .phase_resistance_code(resist), .closed_loop_adjust_span(span),
      .velocity_constant_code(kconst), .advance_method_select(method),
      .advance_time_setting(adv), .advance_delay_cycles(delay));

   // Counts a comparison and reports a mismatch at once.
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   // Addresses the device for writing and sets the register pointer.
   task automatic addr_phase(input motor_fb_pkg::byte_t a);
      logic ack;
      bus_host_model_i.start();
      bus_host_model_i.send({`DEVICE_ADDRESS, 1'b0}, ack);
      check(ack, 1'b1);
      bus_host_model_i.send(a, ack);
      check(ack, 1'b1);
   endtask : addr_phase

   // Writes a burst of bytes from the given register onwards.
   task automatic reg_write(input motor_fb_pkg::byte_t a,
                            input motor_fb_pkg::byte_t d [3]);
      logic ack;
      addr_phase(a);
      foreach (d[i]) begin
         bus_host_model_i.send(d[i], ack);
         check(ack, 1'b1);
      end
      bus_host_model_i.stop();
   endtask : reg_write

   // Reads n bytes into rd through a repeated start; the last is refused.
   task automatic reg_read(input motor_fb_pkg::byte_t a, input int n);
      logic ack;
      addr_phase(a);
      bus_host_model_i.start();
      bus_host_model_i.send({`DEVICE_ADDRESS, 1'b1}, ack);
      check(ack, 1'b1);
      for (int i = 0; i < n; i++) begin
         bus_host_model_i.recv(i == n - 1, rd[i]);
      end
      bus_host_model_i.stop();
   endtask : reg_read

   // Waits for the store copy to finish and the decode to settle.
   task automatic wait_loaded();
      @(posedge clock); // Lets a request made on this edge raise the flag.
      repeat (40) if (loading === 1'b1) @(posedge clock);
      check(loading, 1'b0);
      repeat (2) @(posedge clock);
   endtask : wait_loaded

   // Compares decoded outputs with values worked out from the three bytes.
   task automatic check_params(input motor_fb_pkg::byte_t p1, p2, p3);
      int t;
      t = int'(p3[3:0]) << p3[6:4];
      check(rate, p1[7]);
      check(resist, 24'(p1[3:0]) << p1[6:4]);
      check(span, p2[7]);
      check(kconst, 24'(p2[3:0]) << p2[6:4]);
      check(method, p3[7]);
      check(adv, 24'(t));
      check(delay, 24'((t * `ADVANCE_STEP_NS + 7) / `CLOCK_PERIOD_NS));
   endtask : check_params

   // Measures the cycles between two carrier ticks.
   task automatic tick_gap(input int exp);
      int n;
      n = 0;
      do @(posedge clock); while (tick !== 1'b1 && ++n < 100);
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (tick !== 1'b1 && n < 100);
      check(n, exp);
   endtask : tick_gap

   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : complete_run

   // Cuts a hung run short.
   initial begin
      repeat (60000) @(posedge clock);
      n_errors++;
      complete_run();
   end

   // Main sequence of tests.
   initial begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      wait_loaded();
      check_params(8'h4A, 8'h4E, 8'h2A);
      check(sda_out, 1'b0);
      reg_read(`REG_PARAM1, 3);
      check({rd[0], rd[1], rd[2]}, 24'h4A4E2A);
      $display("test defaults done");
      reg_read(`REG_SPEED_HIGH, 6);
      check({rd[0], rd[1]}, 16'h01FF);
      check({rd[2], rd[3]}, 16'h1234);
      check({rd[4], rd[5]}, 16'hABCD);
      reg_read(`REG_PERIOD_HIGH, 1);
      period <= 16'h5678;
      reg_read(`REG_PERIOD_LOW, 1);
      check(rd[0], 8'h34);
      $display("test wide values done");
      reg_read(`REG_POSITION, 6);
      check(rd[0], 8'h5A);
      check(rd[1], 8'h67);
      check(rd[2], 8'hFF);
      check(rd[3], 8'hAA);
      check(rd[4], 8'h00);
      check(rd[5], 8'h2D);
      supply <= 8'h98;
      faults <= 6'h12;
      reg_read(`REG_SUPPLY, 1);
      check(rd[0], 8'h98);
      reg_read(`REG_FAULTS, 1);
      check(rd[0], 8'h12);
      bus_host_model_i.start();
      bus_host_model_i.send({`DEVICE_ADDRESS ^ 7'h01, 1'b0}, stray_ack);
      check(stray_ack, 1'b0);
      bus_host_model_i.stop();
      $display("test byte values done");
      reg_write(`REG_PARAM1, '{8'hF7, 8'h85, 8'hFF});
      repeat (4) @(posedge clock);
      check_params(8'hF7, 8'h85, 8'hFF);
      reg_read(`REG_PARAM1, 3);
      check({rd[0], rd[1], rd[2]}, 24'hF785FF);
      tick_gap(10);
      $display("test parameter write done");
      reload <= 1'b1;
      @(posedge clock);
      reload <= 1'b0;
      wait_loaded();
      check_params(8'h4A, 8'h4E, 8'h2A);
      tick_gap(20);
      $display("test reload done");
      complete_run();
   end
endmodule : motor_feedback_param_regs_test
`default_nettype wire
